//--- src/hbu_pkg.sv
package hbu_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int WORD_W = 32;
  localparam int IDX_W = 16;

  // ----------------------------------------
  // host address slots (address bits 4:2)
  // ----------------------------------------
  localparam logic [2:0] SLOT_INDEX = 3'h0;
  localparam logic [2:0] SLOT_DATA = 3'h1;

  // ----------------------------------------
  // byte lane bookkeeping
  // ----------------------------------------
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [3:0] LANES_FULL = 4'hf;
  localparam logic [3:0] LANES_LO = 4'h3;
  localparam logic [3:0] LANES_HI = 4'hc;
  localparam logic [3:0] LANE_ONE = 4'h1;
  localparam logic [1:0] BYTE_FIRST = 2'h0;
  localparam logic [1:0] BYTE_LAST = 2'h3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [31:0] DWORD_ZERO = 32'h00000000;
  localparam int BURST_DWORDS = 8;

  // ----------------------------------------
  // pin vector layout and strap settling
  // ----------------------------------------
  localparam int PIN_DATA = 0;
  localparam int PIN_ADDR = 16;
  localparam int PIN_FDS = 21;
  localparam int PIN_WR = 22;
  localparam int PIN_RD = 23;
  localparam int PIN_CS = 24;
  localparam int PIN_STYLE = 25;
  localparam int PIN_RDPOL = 26;
  localparam int PIN_WRPOL = 27;
  localparam int PIN_W = 28;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [1:0] STRAP_STEP = 2'h1;

  // ----------------------------------------
  // write path states
  // ----------------------------------------
  typedef enum logic [1:0] {
    HBU_W_IDLE = 2'b00,
    HBU_W_COMMIT = 2'b01
  } hbu_wstate_t;

  // byte order swap, shared by read and write paths
  function automatic logic [31:0] hbu_order(input logic [31:0] w, input logic big);
    return big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction

endpackage

//--- src/hbu_buf2.sv
`timescale 1ns/1ps
module hbu_buf2
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // fill side
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [hbu_pkg::WORD_W-1:0] s_data,
  // drain side
  output logic m_valid,
  input wire logic m_ready,
  output logic [hbu_pkg::WORD_W-1:0] m_data
);
  import hbu_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] ent0;
    logic [WORD_W-1:0] ent1;
    logic [1:0] cnt;
    logic valid;
    logic ready;
  } hbu_buf_t;

  hbu_buf_t st_reg;
  hbu_buf_t st_next;
  logic push;
  logic pop;

  // ----------------------------------------
  // two entries, ent0 is always the head
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    push = s_valid && st_reg.ready;
    pop = st_reg.valid && m_ready;
    if (pop)
    begin
      st_next.ent0 = st_reg.ent1;
    end
    if (push)
    begin
      if (st_reg.cnt == 2'h0 || (st_reg.cnt == 2'h1 && pop))
      begin
        st_next.ent0 = s_data;
      end
      else
      begin
        st_next.ent1 = s_data;
      end
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
    st_next.valid = st_next.cnt != 2'h0;
    // ready registered: full really blocks the filler
    st_next.ready = st_next.cnt != 2'h2;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '{ent0: '0, ent1: '0, cnt: 2'h0, valid: 1'b0, ready: 1'b1};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign s_ready = st_reg.ready;
  assign m_valid = st_reg.valid;
  assign m_data = st_reg.ent0;

  chk_buf_count: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_reg.cnt != 2'h3)
    else $error("buffer count out of range");
endmodule

//--- src/hbu_host_port.sv
`timescale 1ns/1ps
//
// Overview of operation
// - 16-bit data read, lower then upper word
// - 16-bit data write taken on store trailing edge
// - 8-bit mode uses low lane only
// - fifo select needs no index write
// - burst read up to eight doublewords
// - 16-bit fifo: bit 1 picks word
// - 16-bit burst: fresh data per bit 1
// - bit 2 change pops receive fifo
// - 8-bit burst: fresh data per bit 0
// - 8-bit fifo: bits 1:0 pick byte
// - strap selects direction plus transfer strobe style
// - strobe style applies to every access
// - separate straps set both strobe polarities
// - fifo select: write tx, read rx
// - fifo byte order has own bit
//
module hbu_host_port
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // host pins
  input wire logic chip_select,
  input wire logic rd_or_dir,
  input wire logic wr_or_transfer_strobe,
  input wire logic fifo_direct_select,
  input wire logic [hbu_pkg::ADDR_W-1:0] host_addr,
  input wire logic [hbu_pkg::DATA_W-1:0] host_data_in,
  output logic [hbu_pkg::DATA_W-1:0] host_data_out,
  output logic host_data_oe_lo,
  output logic host_data_oe_hi,
  // straps
  input wire logic strobe_style_strap,
  input wire logic read_direction_polarity_strap,
  input wire logic store_transfer_polarity_strap,
  // configuration from the host bus unit
  input wire logic bus_8bit_mode,
  input wire logic reg_big_endian,
  input wire logic fifo_big_endian,
  // internal register port
  output logic [hbu_pkg::IDX_W-1:0] reg_addr,
  output logic [hbu_pkg::WORD_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [hbu_pkg::WORD_W-1:0] reg_rdata,
  // receive data fifo, show-ahead
  input wire logic [hbu_pkg::WORD_W-1:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // transmit data fifo
  output logic [hbu_pkg::WORD_W-1:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);
  import hbu_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] pins;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic style;
    logic rd_inv;
    logic wr_inv;
    logic rd_q;
    logic wr_q;
    logic fds_q;
    logic [ADDR_W-1:0] a_q;
    logic [DATA_W-1:0] d_q;
    logic [IDX_W-1:0] index;
    logic [WORD_W-1:0] fetched;
    logic fetch_pend;
    logic [WORD_W-1:0] hold;
    logic [3:0] lanes;
    logic hold_fds;
    hbu_wstate_t wstate;
    logic last_seen;
    logic rx_pop;
    logic [DATA_W-1:0] dout;
    logic oe_lo;
    logic oe_hi;
    logic [IDX_W-1:0] int_addr;
    logic [WORD_W-1:0] int_wdata;
    logic int_wr;
    logic int_rd;
    logic push_valid;
    logic [WORD_W-1:0] push_data;
  } hbu_port_t;

  hbu_port_t st_reg;
  hbu_port_t st_next;

  logic [PIN_W-1:0] pin_vec;
  logic cs;
  logic fds;
  logic rd_lvl;
  logic wr_lvl;
  logic rd_act;
  logic wr_act;
  logic rd_rise;
  logic rd_fall;
  logic wr_fall;
  logic a2_flip;
  logic [ADDR_W-1:0] s_addr;
  logic [2:0] slot;
  logic part_first;
  logic part_last;
  logic [WORD_W-1:0] rd_src;
  logic [WORD_W-1:0] rd_word;
  logic [3:0] lanes_new;
  logic buf_ready;

  assign pin_vec = {store_transfer_polarity_strap, read_direction_polarity_strap,
                    strobe_style_strap, chip_select, rd_or_dir, wr_or_transfer_strobe,
                    fifo_direct_select, host_addr, host_data_in};

  always_comb
  begin
    st_next = st_reg;
    // ----------------------------------------
    // synchronisers, meta feeds pins only
    // ----------------------------------------
    st_next.meta = pin_vec;
    st_next.pins = st_reg.meta;

    // ----------------------------------------
    // straps caught once pins have settled
    // ----------------------------------------
    if (!st_reg.strap_done)
    begin
      st_next.strap_cnt = st_reg.strap_cnt + STRAP_STEP;
      if (st_reg.strap_cnt == STRAP_SETTLE)
      begin
        st_next.strap_done = 1'b1;
        st_next.style = st_reg.pins[PIN_STYLE];
        st_next.rd_inv = st_reg.pins[PIN_RDPOL];
        st_next.wr_inv = st_reg.pins[PIN_WRPOL];
      end
    end

    // ----------------------------------------
    // strobe decode, one path for all accesses
    // ----------------------------------------
    cs = st_reg.pins[PIN_CS];
    fds = st_reg.pins[PIN_FDS];
    s_addr = st_reg.pins[PIN_ADDR +: ADDR_W];
    slot = s_addr[4:2];
    rd_lvl = st_reg.pins[PIN_RD] ^ st_reg.rd_inv;
    wr_lvl = st_reg.pins[PIN_WR] ^ st_reg.wr_inv;
    // direction style: rd_lvl high means write, wr_lvl is the transfer strobe
    rd_act = st_reg.strap_done && cs && (st_reg.style ? (wr_lvl && !rd_lvl) : rd_lvl);
    wr_act = st_reg.strap_done && cs && (st_reg.style ? (wr_lvl && rd_lvl) : wr_lvl) && !rd_act;
    rd_rise = rd_act && !st_reg.rd_q;
    rd_fall = st_reg.rd_q && !rd_act;
    wr_fall = st_reg.wr_q && !wr_act;
    a2_flip = rd_act && st_reg.rd_q && fds && st_reg.fds_q && (s_addr[2] != st_reg.a_q[2]);
    part_first = bus_8bit_mode ? (s_addr[1:0] == BYTE_FIRST) : !s_addr[1];
    part_last = bus_8bit_mode ? (s_addr[1:0] == BYTE_LAST) : s_addr[1];
    st_next.rd_q = rd_act;
    st_next.wr_q = wr_act;
    st_next.fds_q = fds;
    st_next.a_q = s_addr;
    st_next.d_q = st_reg.pins[PIN_DATA +: DATA_W];

    // ----------------------------------------
    // read data path
    // ----------------------------------------
    if (fds)
    begin
      rd_src = rx_valid ? rx_data : DWORD_ZERO;
    end
    else if (slot == SLOT_INDEX)
    begin
      rd_src = {WORD_ZERO, st_reg.index};
    end
    else
    begin
      rd_src = st_reg.fetched;
    end
    rd_word = hbu_order(rd_src, fds ? fifo_big_endian : reg_big_endian);
    if (bus_8bit_mode)
    begin
      st_next.dout = {BYTE_ZERO, rd_word[{s_addr[1:0], 3'h0} +: 8]};
    end
    else
    begin
      st_next.dout = rd_word[{s_addr[1], 4'h0} +: 16];
    end
    st_next.oe_lo = rd_act;
    st_next.oe_hi = rd_act && !bus_8bit_mode;

    // fetch the whole register on the first part, later parts read the copy
    st_next.int_rd = 1'b0;
    st_next.fetch_pend = st_reg.int_rd;
    if (st_reg.fetch_pend)
    begin
      st_next.fetched = reg_rdata;
    end
    if (rd_rise && !fds && slot == SLOT_DATA && part_first)
    begin
      st_next.int_rd = 1'b1;
      st_next.int_addr = st_reg.index;
    end

    // ----------------------------------------
    // receive pops: bit 2 change or last part
    // ----------------------------------------
    st_next.rx_pop = 1'b0;
    if (rd_act && fds && part_last)
    begin
      st_next.last_seen = 1'b1;
    end
    if (a2_flip)
    begin
      st_next.rx_pop = rx_valid;
      st_next.last_seen = 1'b0;
    end
    else if (rd_fall && st_reg.fds_q && st_reg.last_seen)
    begin
      st_next.rx_pop = rx_valid;
      st_next.last_seen = 1'b0;
    end
    if (st_reg.rx_pop)
    begin
      // one pop per pulse, the next word needs a cycle to show
      st_next.rx_pop = 1'b0;
    end

    // ----------------------------------------
    // write path: assemble, then commit
    // ----------------------------------------
    st_next.int_wr = 1'b0;
    st_next.push_valid = 1'b0;
    lanes_new = st_reg.lanes;
    case (st_reg.wstate)
      HBU_W_IDLE:
      begin
        if (wr_fall && !st_reg.fds_q && st_reg.a_q[4:2] == SLOT_INDEX)
        begin
          // upper word of the index is reserved
          if (bus_8bit_mode && !st_reg.a_q[1])
          begin
            st_next.index[{st_reg.a_q[0], 3'h0} +: 8] = st_reg.d_q[7:0];
          end
          else if (!bus_8bit_mode && !st_reg.a_q[1])
          begin
            st_next.index = st_reg.d_q;
          end
        end
        else if (wr_fall && (st_reg.fds_q || st_reg.a_q[4:2] == SLOT_DATA))
        begin
          if (bus_8bit_mode)
          begin
            st_next.hold[{st_reg.a_q[1:0], 3'h0} +: 8] = st_reg.d_q[7:0];
            lanes_new = st_reg.lanes | (LANE_ONE << st_reg.a_q[1:0]);
          end
          else
          begin
            st_next.hold[{st_reg.a_q[1], 4'h0} +: 16] = st_reg.d_q;
            lanes_new = st_reg.lanes | (st_reg.a_q[1] ? LANES_HI : LANES_LO);
          end
          st_next.lanes = lanes_new;
          st_next.hold_fds = st_reg.fds_q;
          if (lanes_new == LANES_FULL)
          begin
            st_next.wstate = HBU_W_COMMIT;
          end
        end
      end
      HBU_W_COMMIT:
      begin
        // host writes arriving while a commit waits are dropped
        if (!st_reg.hold_fds)
        begin
          st_next.int_wr = 1'b1;
          st_next.int_addr = st_reg.index;
          st_next.int_wdata = hbu_order(st_reg.hold, reg_big_endian);
          st_next.lanes = LANES_NONE;
          st_next.wstate = HBU_W_IDLE;
        end
        else if (buf_ready && !st_reg.push_valid)
        begin
          st_next.push_valid = 1'b1;
          st_next.push_data = hbu_order(st_reg.hold, fifo_big_endian);
          st_next.lanes = LANES_NONE;
          st_next.wstate = HBU_W_IDLE;
        end
      end
      default:
      begin
        st_next.wstate = HBU_W_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // transmit buffer, stalls fifo commits when full
  // ----------------------------------------
  hbu_buf2 u_txbuf
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .s_valid(st_reg.push_valid),
    .s_ready(buf_ready),
    .s_data(st_reg.push_data),
    .m_valid(tx_valid),
    .m_ready(tx_ready),
    .m_data(tx_data)
  );

  assign host_data_out = st_reg.dout;
  assign host_data_oe_lo = st_reg.oe_lo;
  assign host_data_oe_hi = st_reg.oe_hi;
  assign reg_addr = st_reg.int_addr;
  assign reg_wdata = st_reg.int_wdata;
  assign reg_wr = st_reg.int_wr;
  assign reg_rd = st_reg.int_rd;
  assign rx_ready = st_reg.rx_pop;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  chk_hi_lane_quiet: assert property (bus_8bit_mode && $past(bus_8bit_mode) |-> !host_data_oe_hi)
    else $error("upper data lane driven in 8-bit mode");
  chk_read_drive: assert property (rd_act && !bus_8bit_mode |=> host_data_oe_lo && host_data_oe_hi)
    else $error("data lanes not driven during read");
  chk_pop_on_a2: assert property (a2_flip && rx_valid && !st_reg.rx_pop |=> rx_ready)
    else $error("no pop after address bit 2 change");
  chk_commit_full: assert property ($rose(reg_wr) |-> $past(st_reg.lanes) == LANES_FULL)
    else $error("register written before all parts arrived");
  chk_tx_from_fds: assert property (st_reg.push_valid |-> st_reg.hold_fds && $past(st_reg.wstate) == HBU_W_COMMIT)
    else $error("transmit push without fifo select");
  chk_fds_commit: assert property (st_reg.wstate == HBU_W_COMMIT && st_reg.hold_fds && buf_ready && !st_reg.push_valid |=> st_reg.push_valid)
    else $error("fifo write not pushed");
  chk_dir_style: assert property (st_reg.strap_done && st_reg.style && cs && wr_lvl && !rd_lvl |=> host_data_oe_lo)
    else $error("direction style read not served");
  chk_word_capture: assert property (wr_fall && st_reg.wstate == HBU_W_IDLE && st_reg.fds_q && !bus_8bit_mode && !st_reg.a_q[1] |=> st_reg.hold[15:0] == $past(st_reg.d_q))
    else $error("lower word not captured on trailing edge");
  chk_byte_select: assert property (rd_act && fds && bus_8bit_mode && !fifo_big_endian && rx_valid && s_addr[1:0] == BYTE_FIRST |=> host_data_out[7:0] == $past(rx_data[7:0]))
    else $error("wrong fifo byte presented");
  chk_fetch_index: assert property (reg_rd |-> reg_addr == $past(st_reg.index))
    else $error("register fetch not at index address");

  cov_burst_pop: cover property (a2_flip && rx_valid);
  cov_reg_write: cover property (reg_wr);
  cov_tx_push: cover property (st_reg.push_valid && buf_ready);
  cov_tx_stall: cover property (st_reg.wstate == HBU_W_COMMIT && st_reg.hold_fds && !buf_ready);
endmodule

//--- dv/hbu_far_model.sv
`timescale 1ns/1ps
module hbu_far_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // bench control
  input wire logic hold_tx,
  // internal register port
  input wire logic [hbu_pkg::IDX_W-1:0] reg_addr,
  input wire logic [hbu_pkg::WORD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [hbu_pkg::WORD_W-1:0] reg_rdata,
  // receive fifo
  output logic [hbu_pkg::WORD_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // transmit fifo
  input wire logic [hbu_pkg::WORD_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  import hbu_pkg::*;
  // flat store over the whole index space; only written words are ever read back
  logic [WORD_W-1:0] regs [2**IDX_W];
  logic [WORD_W-1:0] rx_q [$];
  logic [WORD_W-1:0] tx_q [$];
  logic [1:0] stall_cnt;
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 32'h00000000;
      rx_data <= 32'h00000000;
      rx_valid <= 1'b0;
      tx_ready <= 1'b0;
      stall_cnt <= 2'h0;
    end
    else
    begin
      // read data stand one cycle only, then scramble so stale use shows
      reg_rdata <= reg_rd ? regs[reg_addr] : ~reg_rdata;
      if (reg_wr)
        regs[reg_addr] = reg_wdata;
      if (rx_ready && rx_q.size() > 0)
        void'(rx_q.pop_front());
      rx_valid <= rx_q.size() > 0;
      rx_data <= rx_q.size() > 0 ? rx_q[0] : ~rx_data;
      if (tx_valid && tx_ready)
        tx_q.push_back(tx_data);
      // drain stalls one cycle in four, and fully while held
      stall_cnt <= stall_cnt + 2'h1;
      tx_ready <= !hold_tx && stall_cnt != 2'h3;
    end
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import hbu_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic chip_select = 1'b0, rd_or_dir = 1'b0, wr_or_transfer_strobe = 1'b0;
  logic fifo_direct_select = 1'b0;
  logic [ADDR_W-1:0] host_addr = 5'h00;
  logic [DATA_W-1:0] host_data_in = 16'h0000;
  logic style = 1'b0, rpol = 1'b0, wpol = 1'b0;
  logic mode8 = 1'b0, reg_be = 1'b0, fifo_be = 1'b0, hold_tx = 1'b0;
  logic [DATA_W-1:0] host_data_out;
  logic host_data_oe_lo, host_data_oe_hi, reg_wr, reg_rd, rx_valid, rx_ready;
  logic tx_valid, tx_ready;
  logic [IDX_W-1:0] reg_addr;
  logic [WORD_W-1:0] reg_wdata, reg_rdata, rx_data, tx_data;
  int bad_count = 0;
  int samples_checked = 0;
  logic [31:0] lfsr = 32'h8721f356;
  logic [31:0] rx_exp [$];
  logic [31:0] tx_exp [$];

  always #5 core_clk = ~core_clk;

  hbu_host_port i_dut (.core_clk(core_clk), .arst_n(arst_n), .chip_select(chip_select),
    .rd_or_dir(rd_or_dir), .wr_or_transfer_strobe(wr_or_transfer_strobe),
    .fifo_direct_select(fifo_direct_select), .host_addr(host_addr),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe_lo(host_data_oe_lo), .host_data_oe_hi(host_data_oe_hi),
    .strobe_style_strap(style), .read_direction_polarity_strap(rpol),
    .store_transfer_polarity_strap(wpol), .bus_8bit_mode(mode8),
    .reg_big_endian(reg_be), .fifo_big_endian(fifo_be), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  hbu_far_model i_far (.core_clk(core_clk), .arst_n(arst_n), .hold_tx(hold_tx),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report;
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic void rnd(output logic [31:0] v);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    v = lfsr;
  endfunction

  // host lane view of a dword: swap first, then pick word or byte
  function automatic logic [15:0] pick(input logic [31:0] w, input logic be, input logic [1:0] a);
    logic [31:0] s;
    s = be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    return mode8 ? {8'h00, s[8*a +: 8]} : s[16*a[1] +: 16];
  endfunction

  // one pin update; strobe style and polarity applied here only
  task automatic drive(input logic rd, input logic wr, input logic fds, input logic [4:0] a,
                       input logic [15:0] d);
    @(posedge core_clk);
    chip_select <= rd | wr;
    fifo_direct_select <= fds;
    host_addr <= a;
    host_data_in <= wr ? d : ~host_data_in;
    rd_or_dir <= (style ? wr : rd) ^ rpol;
    wr_or_transfer_strobe <= (style ? (rd | wr) : wr) ^ wpol;
  endtask

  task automatic xfer(input logic wr, input logic fds, input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    drive(!wr, wr, fds, a, d);
    repeat (8) @(posedge core_clk);
    #1;
    q = host_data_out & (mode8 ? 16'h00ff : 16'hffff);
    check("oe_lo", host_data_oe_lo, !wr);
    check("oe_hi", host_data_oe_hi, !wr && !mode8);
    drive(1'b0, 1'b0, fds, a, d);
    repeat (4) @(posedge core_clk);
  endtask

  task automatic dword(input logic wr, input logic fds, input logic [2:0] slot,
                       input logic [31:0] w, input logic be);
    logic [15:0] q;
    logic [4:0] a;
    for (logic [2:0] p = 3'h0; p < (mode8 ? 3'h4 : 3'h2); p++)
    begin
      a = {slot, mode8 ? p[1:0] : {p[0], 1'b0}};
      xfer(wr, fds, a, pick(w, be, a[1:0]), q);
      if (!wr)
        check("read_data", q, pick(w, be, a[1:0]));
    end
  endtask

  task automatic burst(input int n);
    logic [15:0] q;
    logic [31:0] w;
    logic [4:0] a;
    for (int i = 0; i < n * (mode8 ? 4 : 2); i++)
    begin
      a = mode8 ? i[4:0] : {i[3:0], 1'b0};
      if (a[1:0] == 2'h0)
        w = rx_exp.pop_front();
      drive(1'b1, 1'b0, 1'b1, a, 16'h0000);
      repeat (7) @(posedge core_clk);
      #1;
      q = host_data_out & (mode8 ? 16'h00ff : 16'hffff);
      check("burst_data", q, pick(w, fifo_be, a[1:0]));
    end
    drive(1'b0, 1'b0, 1'b1, a, 16'h0000);
    repeat (6) @(posedge core_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reg_test(input logic be);
    logic [31:0] w, idx;
    rnd(idx);
    @(posedge core_clk);
    reg_be <= 1'b0;
    dword(1'b1, 1'b0, SLOT_INDEX, {16'h0000, idx[15:0]}, 1'b0);
    dword(1'b0, 1'b0, SLOT_INDEX, {16'h0000, idx[15:0]}, 1'b0);
    reg_be <= be;
    for (int k = 0; k < 3; k++)
    begin
      rnd(w);
      dword(1'b1, 1'b0, SLOT_DATA, w, be);
      // commit lands a few edges after the last trailing edge
      repeat (3) @(posedge core_clk);
      check("reg_store", i_far.regs[idx[15:0]], w);
      dword(1'b0, 1'b0, SLOT_DATA, w, be);
    end
  endtask

  task automatic fifo_test(input logic be);
    logic [31:0] w, r;
    @(posedge core_clk);
    fifo_be <= be;
    hold_tx <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      rnd(w);
      rnd(r);
      tx_exp.push_back(w);
      dword(1'b1, 1'b1, r[2:0], w, be);
    end
    check("tx_held_valid", tx_valid, 1'b1);
    check("tx_held_count", i_far.tx_q.size(), 0);
    hold_tx <= 1'b0;
    for (int t = 0; t < 300 && i_far.tx_q.size() < 3; t++)
      @(posedge core_clk);
    check("tx_count", i_far.tx_q.size(), 3);
    if (i_far.tx_q.size() < 3)
      final_report();
    while (i_far.tx_q.size() > 0)
      check("tx_data", i_far.tx_q.pop_front(), tx_exp.pop_front());
    for (int k = 0; k < 12; k++)
    begin
      rnd(w);
      rx_exp.push_back(w);
      i_far.rx_q.push_back(w);
    end
    dword(1'b0, 1'b1, r[4:2], rx_exp.pop_front(), be);
    burst(8);
    burst(3);
    check("rx_left", i_far.rx_q.size(), 0);
  endtask

  initial
  begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    final_report();
  end

  // both strobe styles, each with both bus widths
  initial
  begin
    for (int s = 0; s < 2; s++)
    begin
      @(posedge core_clk);
      arst_n <= 1'b0;
      style <= s[0];
      rpol <= s[0];
      wpol <= ~s[0];
      drive(1'b0, 1'b0, 1'b0, 5'h00, 16'h0000);
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      for (int m = 0; m < 2; m++)
      begin
        mode8 <= m[0];
        reg_test(m[0] ^ s[0]);
        fifo_test(m[0] ^ s[0]);
      end
    end
    final_report();
  end
endmodule
